// ==== hw/cps_defines.vh ====
`ifndef CPS_DEFINES_VH
`define CPS_DEFINES_VH

// widths of the stored stream
`define CPS_DATA_W     8
`define CPS_ADDR_W     10
`define CPS_REV_W      2

// system clock period and derived timing counts
`define CPS_CLK_NS     10
`define CPS_POR_NS     1000
`define CPS_POR_CYC    ((`CPS_POR_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)
`define CPS_CFG_NS     500
`define CPS_CFG_CYC    ((`CPS_CFG_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)
`define CPS_CNT_W      8

// internal oscillator: half period in system clocks
`define CPS_OSC_DIV    4
`define CPS_OSC_W      8

// test access port instruction register
`define CPS_IR_W       8
`define CPS_IR_BYPASS  8'hff
`define CPS_IR_CONFIG  8'hee
`define CPS_IR_CAPTURE 8'h01

// pulled levels of undriven pins
`define CPS_PULL_BUSY  1'b0
`define CPS_PULL_REV   1'b1
`define CPS_PULL_EXT   1'b1

`endif

// ==== hw/cps_mem.v ====
`timescale 1ns/1ps
module cps_mem #(
  parameter DATA_W = 8,
  parameter ADDR_W = 10
) (
  // clock
  input  wire              clk_i,
  // write port
  input  wire              we_i,
  input  wire [ADDR_W-1:0] waddr_i,
  input  wire [DATA_W-1:0] wdata_i,
  // read port
  input  wire [ADDR_W-1:0] raddr_i,
  output reg  [DATA_W-1:0] rdata_o
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

// ==== hw/cps_sequencer.v ====
`timescale 1ns/1ps
`include "cps_defines.vh"
module cps_sequencer #(
  parameter DATA_W  = `CPS_DATA_W,
  parameter ADDR_W  = `CPS_ADDR_W,
  parameter OSC_DIV = `CPS_OSC_DIV
) (
  // clock and reset
  input  wire                  clk_i,
  input  wire                  rst_i,
  // chip select and open-drain output enable / reset
  input  wire                  ce_n_i,
  input  wire                  oe_rst_n_i,
  output reg                   oe_rst_n_o,
  output reg                   oe_rst_n_oe_n_o,
  // open-drain configuration pulse
  input  wire                  config_pulse_n_i,
  output reg                   config_pulse_n_o,
  output reg                   config_pulse_n_oe_n_o,
  // external configuration clock and flow control
  input  wire                  ext_clk_i,
  input  wire                  busy_i,
  input  wire                  busy_drv_i,
  // revision pick pins, each with a driven flag
  input  wire                  revision_pick_bit0_i,
  input  wire                  revision_pick_bit1_i,
  input  wire [1:0]            revision_pick_drv_i,
  input  wire                  external_revision_pick_en_i,
  input  wire                  external_revision_pick_en_drv_i,
  // programmed control bits
  input  wire                  clock_out_en_i,
  input  wire                  clk_src_int_i,
  input  wire                  parallel_mode_i,
  input  wire                  decompress_i,
  input  wire                  data_ready_i,
  input  wire [1:0]            rev_bits_i,
  input  wire [4*ADDR_W-1:0]   rev_start_i,
  input  wire [4*ADDR_W-1:0]   rev_last_i,
  // stream memory load port
  input  wire                  mem_we_i,
  input  wire [ADDR_W-1:0]     mem_waddr_i,
  input  wire [DATA_W-1:0]     mem_wdata_i,
  // stream outputs
  output wire [DATA_W-1:0]     data_o,
  output reg                   data_oe_n_o,
  output reg                   config_clock_out_o,
  output reg                   config_clock_out_oe_n_o,
  output reg                   cascade_enable_out_o,
  // test access port
  input  wire                  tck_i,
  input  wire                  tms_i,
  input  wire                  tdi_i,
  output reg                   tdo_o,
  output reg                   tdo_oe_n_o
);

  localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDS = 16'h0004, S_CDR = 16'h0008;
  localparam [15:0] S_SDR = 16'h0010, S_E1D = 16'h0020, S_PDR = 16'h0040, S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100, S_SIS = 16'h0200, S_CIR = 16'h0400, S_SIR = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000, S_PIR = 16'h2000, S_E2I = 16'h4000, S_UIR = 16'h8000;

  localparam integer          POR_CYC_I = `CPS_POR_CYC;
  localparam integer          CFG_CYC_I = `CPS_CFG_CYC;
  localparam integer          OSC_END_I = OSC_DIV - 1;
  localparam [`CPS_CNT_W-1:0] POR_CYC   = POR_CYC_I[`CPS_CNT_W-1:0];
  localparam [`CPS_CNT_W-1:0] CFG_CYC   = CFG_CYC_I[`CPS_CNT_W-1:0];
  localparam [`CPS_OSC_W-1:0] OSC_END   = OSC_END_I[`CPS_OSC_W-1:0];

  // slice one revision's address out of a packed table
  function [ADDR_W-1:0] rev_addr;
    input [4*ADDR_W-1:0] tbl;
    input [1:0]          idx;
    begin
      rev_addr = tbl[idx*ADDR_W +: ADDR_W];
    end
  endfunction

  // test port next state
  function [15:0] tap_next;
    input [15:0] st;
    input        tms;
    begin
      case (st)
        S_TLR:   tap_next = tms ? S_TLR : S_RTI;
        S_RTI:   tap_next = tms ? S_SDS : S_RTI;
        S_SDS:   tap_next = tms ? S_SIS : S_CDR;
        S_CDR:   tap_next = tms ? S_E1D : S_SDR;
        S_SDR:   tap_next = tms ? S_E1D : S_SDR;
        S_E1D:   tap_next = tms ? S_UDR : S_PDR;
        S_PDR:   tap_next = tms ? S_E2D : S_PDR;
        S_E2D:   tap_next = tms ? S_UDR : S_SDR;
        S_UDR:   tap_next = tms ? S_SDS : S_RTI;
        S_SIS:   tap_next = tms ? S_TLR : S_CIR;
        S_CIR:   tap_next = tms ? S_E1I : S_SIR;
        S_SIR:   tap_next = tms ? S_E1I : S_SIR;
        S_E1I:   tap_next = tms ? S_UIR : S_PIR;
        S_PIR:   tap_next = tms ? S_E2I : S_PIR;
        S_E2I:   tap_next = tms ? S_UIR : S_SIR;
        S_UIR:   tap_next = tms ? S_SDS : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  reg  [ADDR_W-1:0]      addr_q, addr_d;
  reg  [1:0]             rev_q, rev_d;
  reg                    passed_q, passed_d;
  reg                    pulse_prev_q;
  reg                    ext_prev_q;
  reg  [`CPS_OSC_W-1:0]  osc_cnt_q;
  reg                    osc_q;
  reg  [`CPS_CNT_W-1:0]  por_cnt_q;
  reg  [`CPS_CNT_W-1:0]  cfg_cnt_q;
  reg                    tck_prev_q;
  reg  [15:0]            tap_q;
  reg  [`CPS_IR_W-1:0]   ir_sh_q;
  reg  [`CPS_IR_W-1:0]   ir_q;
  reg                    bypass_q;

  wire       busy_pin = busy_drv_i ? busy_i : `CPS_PULL_BUSY;
  wire [1:0] pick_pins = {revision_pick_drv_i[1] ? revision_pick_bit1_i : `CPS_PULL_REV,
                          revision_pick_drv_i[0] ? revision_pick_bit0_i : `CPS_PULL_REV};
  wire       ext_en_n = external_revision_pick_en_drv_i ? external_revision_pick_en_i : `CPS_PULL_EXT;
  wire [1:0] rev_sel = ext_en_n ? rev_bits_i : pick_pins;
  wire       busy_eff = parallel_mode_i & ~decompress_i & busy_pin;
  wire       active = ~ce_n_i & oe_rst_n_i;
  wire       pulse_rise = config_pulse_n_i & ~pulse_prev_q;
  wire       osc_tick = (osc_cnt_q == OSC_END);
  wire       osc_rise = osc_tick & ~osc_q;
  wire       ext_rise = ext_clk_i & ~ext_prev_q;
  wire       src_rise = clk_src_int_i ? osc_rise : ext_rise;
  wire       avail = ~decompress_i | data_ready_i;
  wire       advance = src_rise & active & config_pulse_n_i & avail & ~busy_eff & ~passed_q;
  wire       osc_d = osc_tick ? ~osc_q : osc_q;

  // address counter and revision latch
  always @* begin
    addr_d   = addr_q;
    rev_d    = rev_q;
    passed_d = passed_q;
    if (pulse_rise) begin
      rev_d    = rev_sel;
      addr_d   = rev_addr(rev_start_i, rev_sel);
      passed_d = 1'b0;
    end else if (advance) begin
      if (addr_q == rev_addr(rev_last_i, rev_q)) begin
        passed_d = 1'b1;
      end
      addr_d = addr_q + 1'b1;
    end
    if (!active) begin
      addr_d   = rev_addr(rev_start_i, rev_d);
      passed_d = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_q     <= {ADDR_W{1'b0}};
      rev_q      <= 2'b00;
      passed_q   <= 1'b0;
      pulse_prev_q <= 1'b1;
      ext_prev_q <= 1'b0;
      osc_cnt_q  <= {`CPS_OSC_W{1'b0}};
      osc_q      <= 1'b0;
    end else begin
      addr_q     <= addr_d;
      rev_q      <= rev_d;
      passed_q   <= passed_d;
      pulse_prev_q <= config_pulse_n_i;
      ext_prev_q <= ext_clk_i;
      osc_cnt_q  <= osc_tick ? {`CPS_OSC_W{1'b0}} : osc_cnt_q + 1'b1;
      osc_q      <= osc_d;
    end
  end

  // data read at the next address so data_o tracks addr_q
  cps_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we_i),
    .waddr_i (mem_waddr_i),
    .wdata_i (mem_wdata_i),
    .raddr_i (addr_d),
    .rdata_o (data_o)
  );

  // output pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      data_oe_n_o             <= 1'b1;
      config_clock_out_o      <= 1'b1;
      config_clock_out_oe_n_o <= 1'b1;
      cascade_enable_out_o    <= 1'b1;
    end else begin
      data_oe_n_o             <= ~active;
      config_clock_out_oe_n_o <= ~(clock_out_en_i & active);
      if (decompress_i & ~data_ready_i) begin
        config_clock_out_o <= 1'b1;
      end else begin
        config_clock_out_o <= clk_src_int_i ? osc_d : ext_clk_i;
      end
      cascade_enable_out_o    <= ~(active & passed_d);
    end
  end

  // power-on hold of output enable / reset and configuration pulse driver
  always @(posedge clk_i) begin
    if (rst_i) begin
      por_cnt_q             <= POR_CYC;
      cfg_cnt_q             <= {`CPS_CNT_W{1'b0}};
      oe_rst_n_o            <= 1'b0;
      oe_rst_n_oe_n_o       <= 1'b0;
      config_pulse_n_o      <= 1'b0;
      config_pulse_n_oe_n_o <= 1'b1;
    end else begin
      if (por_cnt_q != {`CPS_CNT_W{1'b0}}) begin
        por_cnt_q <= por_cnt_q - 1'b1;
      end
      oe_rst_n_oe_n_o <= (por_cnt_q <= {{(`CPS_CNT_W-1){1'b0}}, 1'b1});
      if (tck_i & ~tck_prev_q & (tap_q == S_UIR) & (ir_sh_q == `CPS_IR_CONFIG)) begin
        cfg_cnt_q <= CFG_CYC;
      end else if (cfg_cnt_q != {`CPS_CNT_W{1'b0}}) begin
        cfg_cnt_q <= cfg_cnt_q - 1'b1;
      end
      config_pulse_n_oe_n_o <= ~(cfg_cnt_q > {{(`CPS_CNT_W-1){1'b0}}, 1'b1});
    end
  end

  // test access port, test clock sampled in the system clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      tck_prev_q <= 1'b0;
      tap_q      <= S_TLR;
      ir_sh_q    <= `CPS_IR_BYPASS;
      ir_q       <= `CPS_IR_BYPASS;
      bypass_q   <= 1'b0;
      tdo_o      <= 1'b1;
      tdo_oe_n_o <= 1'b1;
    end else begin
      tck_prev_q <= tck_i;
      if (tck_i & ~tck_prev_q) begin
        tap_q <= tap_next(tap_q, tms_i);
        case (tap_q)
          S_TLR:   ir_q <= `CPS_IR_BYPASS;
          S_CIR:   ir_sh_q <= `CPS_IR_CAPTURE;
          S_SIR:   ir_sh_q <= {tdi_i, ir_sh_q[`CPS_IR_W-1:1]};
          S_UIR:   ir_q <= ir_sh_q;
          S_CDR:   bypass_q <= 1'b0;
          S_SDR:   bypass_q <= tdi_i;
          default: bypass_q <= bypass_q;
        endcase
      end
      if (~tck_i & tck_prev_q) begin
        tdo_o      <= (tap_q == S_SIR) ? ir_sh_q[0] : bypass_q;
        tdo_oe_n_o <= ~((tap_q == S_SIR) | (tap_q == S_SDR));
      end
    end
  end

endmodule

// ==== verif/cps_props.sv ====
`timescale 1ns/1ps
module cps_props #(
  parameter DATA_W = 8
) (
  // clock, reset and controls
  input wire              clk_i,
  input wire              rst_i,
  input wire              ce_n_i,
  input wire              oe_rst_n_i,
  input wire              config_pulse_n_i,
  input wire              ext_clk_i,
  input wire              busy_i,
  input wire              busy_drv_i,
  input wire              clock_out_en_i,
  input wire              clk_src_int_i,
  input wire              parallel_mode_i,
  input wire              decompress_i,
  input wire              data_ready_i,
  input wire              mem_we_i,
  // stream outputs
  input wire [DATA_W-1:0] data_o,
  input wire              data_oe_n_o,
  input wire              config_clock_out_o,
  input wire              config_clock_out_oe_n_o,
  input wire              cascade_enable_out_o
);
  wire sel = !ce_n_i && oe_rst_n_i;
  wire run = sel && config_pulse_n_i && !mem_we_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_stall; (run && parallel_mode_i && !decompress_i && busy_i && busy_drv_i)[*3]; endsequence
  sequence s_quiet; (run && !clk_src_int_i && $stable(ext_clk_i))[*6]; endsequence
  sequence s_follow; (run && clock_out_en_i && !clk_src_int_i && !decompress_i && $stable(ext_clk_i))[*4]; endsequence
  sequence s_park; (decompress_i && !data_ready_i)[*2]; endsequence
  chk_casc_needs_sel: assert property (!cascade_enable_out_o |-> $past(sel))
    else $error("cascade enable low while not selected");
  chk_casc_release: assert property (!sel |=> cascade_enable_out_o)
    else $error("cascade enable not released");
  chk_desel_float: assert property (ce_n_i |=> data_oe_n_o && config_clock_out_oe_n_o)
    else $error("outputs driven while deselected");
  chk_reset_float: assert property (!oe_rst_n_i |=> data_oe_n_o && config_clock_out_oe_n_o)
    else $error("outputs driven while held in reset");
  chk_busy_holds: assert property (s_stall |-> $stable(data_o))
    else $error("data moved while busy");
  chk_quiet_holds: assert property (s_quiet |-> $stable(data_o))
    else $error("data moved without a source edge");
  chk_clk_follows: assert property (s_follow |-> config_clock_out_o == ext_clk_i)
    else $error("clock output does not follow source");
  chk_clk_parked: assert property (s_park |-> config_clock_out_o)
    else $error("clock output not parked high");
endmodule
bind cps_sequencer cps_props #(.DATA_W(DATA_W)) u_props (.*);

// ==== verif/cps_fpga_model.sv ====
`timescale 1ns/1ps
module cps_fpga_model (
  // clock and bench requests
  input  wire       clk_i,
  input  wire       step_i,
  input  wire       stall_i,
  // stream pins
  input  wire [7:0] data_i,
  input  wire       cclk_i,
  output wire       ext_clk_o,
  output reg        busy_o,
  output wire       busy_drv_o,
  output reg  [7:0] word_o
);
  reg [2:0] cnt_q = 3'h0;
  reg       cclk_q = 1'b0;
  // one source pulse per request, three cycles high; still between requests
  assign ext_clk_o = cnt_q > 3'h3;
  assign busy_drv_o = stall_i;
  initial busy_o = 1'b0;
  always @(posedge clk_i) begin
    cclk_q <= cclk_i;
    busy_o <= stall_i | ~busy_o;
    if (step_i) begin
      cnt_q <= 3'h6;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
    if (cclk_i && !cclk_q) begin
      word_o <= data_i;
    end
  end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic       clk_i = 1'b0, rst_i = 1'b1, ce_n_i = 1'b0, oe_drv = 1'b1, pulse_drv = 1'b1, step = 1'b0, stall = 1'b0;
  logic       revision_pick_bit0_i = 1'b1, revision_pick_bit1_i = 1'b1, external_revision_pick_en_i = 1'b1;
  logic       external_revision_pick_en_drv_i = 1'b0, clock_out_en_i = 1'b1, clk_src_int_i = 1'b0, tck_i = 1'b0;
  logic       parallel_mode_i = 1'b0, decompress_i = 1'b0, data_ready_i = 1'b1, mem_we_i = 1'b0, tms_i = 1'b1;
  logic       tdi_i = 1'b1;
  logic [1:0] revision_pick_drv_i = 2'h0, rev_bits_i = 2'h0;
  logic [9:0] mem_waddr_i = 10'h000;
  logic [7:0] mem_wdata_i = 8'h00, mem [0:255];
  wire [39:0] rev_start_i = {10'h0c0, 10'h080, 10'h040, 10'h010};
  wire [39:0] rev_last_i = {10'h0c5, 10'h085, 10'h045, 10'h015};
  wire        oe_rst_n_i, config_pulse_n_i, ext_clk_i, busy_i, busy_drv_i, oe_rst_n_o, oe_rst_n_oe_n_o, tdo_o;
  wire        config_pulse_n_o, config_pulse_n_oe_n_o, data_oe_n_o, config_clock_out_o, tdo_oe_n_o;
  wire        config_clock_out_oe_n_o, cascade_enable_out_o;
  wire [7:0]  data_o, fpga_word;
  int         fails = 0, tests_run = 0, cyc = 0;
  // open-drain wires: the device pulls low while its enable is low
  assign oe_rst_n_i = oe_rst_n_oe_n_o ? oe_drv : 1'b0;
  assign config_pulse_n_i = config_pulse_n_oe_n_o ? pulse_drv : 1'b0;
  cps_sequencer dut (.*);
  cps_fpga_model u_fpga (.clk_i, .step_i(step), .stall_i(stall), .data_i(data_o), .cclk_i(config_clock_out_o),
                         .ext_clk_o(ext_clk_i), .busy_o(busy_i), .busy_drv_o(busy_drv_i), .word_o(fpga_word));
  always #5 clk_i = ~clk_i;
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk_word(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // one test clock period: rise after one edge, fall two edges later
  task tck_pulse(input logic m, input logic d);
    @(posedge clk_i);
    tms_i <= m;
    tdi_i <= d;
    tck_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    tck_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [9:0] start_of(input logic [1:0] r);
    return (r == 2'h0) ? 10'h010 : {2'h0, r, 6'h00};
  endfunction
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      $display("wrong value at %0t: run too long", $time);
      stop_test();
    end
  end
  initial begin
    logic [1:0] md, r, rv;
    logic [7:0] w;
    logic [9:0] st;
    logic       b, rdy, c0;
    int         adv, n;
    void'($urandom(15666));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (n = 0; n < 256; n++) begin
      w = 8'($urandom);
      mem[n] = w;
      @(posedge clk_i);
      mem_we_i <= 1'b1;
      mem_waddr_i <= 10'(n);
      mem_wdata_i <= w;
    end
    @(posedge clk_i);
    mem_we_i <= 1'b0;
    for (n = 0; n < 300 && oe_rst_n_oe_n_o !== 1'b1; n++) @(posedge clk_i);
    #1;
    chk_bit(oe_rst_n_oe_n_o, 1'b1);
    chk_bit(oe_rst_n_o, 1'b0);
    for (int k = 0; k < 16; k++) begin
      md = 2'(k >> 2);
      r = 2'(k);
      rv = (md == 2'h3) ? 2'h3 : r;
      st = start_of(rv);
      @(posedge clk_i);
      external_revision_pick_en_i <= (md == 2'h1);
      external_revision_pick_en_drv_i <= (md != 2'h2);
      {revision_pick_bit1_i, revision_pick_bit0_i} <= (md == 2'h0) ? r : ~r;
      revision_pick_drv_i <= (md == 2'h3) ? 2'h0 : 2'h3;
      rev_bits_i <= r;
      parallel_mode_i <= k[0];
      decompress_i <= (r == 2'h3);
      clock_out_en_i <= k[0] | k[2];
      pulse_drv <= 1'b0;
      repeat (3) @(posedge clk_i);
      pulse_drv <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1;
      chk_word(data_o, mem[st]);
      adv = 0;
      for (n = 0; n < 40 && adv < 6; n++) begin
        b = 1'($urandom);
        rdy = !decompress_i || ($urandom % 4 != 0);
        @(posedge clk_i);
        step <= 1'b1;
        stall <= b;
        data_ready_i <= rdy;
        @(posedge clk_i);
        step <= 1'b0;
        repeat (9) @(posedge clk_i);
        #1;
        adv += (!(b && parallel_mode_i && !decompress_i) && rdy);
        chk_word(fpga_word, mem[st + 10'(adv)]);
        if (!rdy) chk_bit(config_clock_out_o, 1'b1);
        if (adv < 6) chk_word(data_o, mem[st + 10'(adv)]);
        chk_bit(cascade_enable_out_o, adv < 6);
        @(posedge clk_i);
        stall <= 1'b0;
        data_ready_i <= 1'b1;
      end
      @(posedge clk_i);
      if (k[0]) ce_n_i <= 1'b1;
      else oe_drv <= 1'b0;
      @(posedge clk_i);
      ce_n_i <= 1'b0;
      oe_drv <= 1'b1;
      #1;
      chk_bit(cascade_enable_out_o, 1'b1);
      chk_bit(data_oe_n_o, 1'b1);
      chk_bit(config_clock_out_oe_n_o, 1'b1);
      $display("test %0d done", k);
    end
    // walk the test port to update-ir with the configure instruction
    tck_pulse(1'b0, 1'b1);
    tck_pulse(1'b1, 1'b1);
    tck_pulse(1'b1, 1'b1);
    tck_pulse(1'b0, 1'b1);
    tck_pulse(1'b0, 1'b1);
    chk_bit(tdo_oe_n_o, 1'b0);
    chk_bit(tdo_o, 1'b1);
    for (n = 0; n < 8; n++) begin
      tck_pulse(n == 7, 1'(8'hee >> n));
      if (n < 7) chk_bit(tdo_o, 1'(8'h01 >> (n + 1)));
      else chk_bit(tdo_oe_n_o, 1'b1);
    end
    tck_pulse(1'b1, 1'b1);
    tck_pulse(1'b0, 1'b1);
    chk_bit(config_pulse_n_i, 1'b0);
    chk_bit(config_pulse_n_o, 1'b0);
    repeat (60) @(posedge clk_i);
    #1;
    chk_bit(config_pulse_n_oe_n_o, 1'b1);
    chk_word(data_o, mem[start_of(2'h3)]);
    $display("test tap done");
    // internal oscillator runs the counter to its end
    @(posedge clk_i);
    clk_src_int_i <= 1'b1;
    repeat (120) @(posedge clk_i);
    #1;
    chk_word(data_o, mem[start_of(2'h3) + 10'h006]);
    chk_bit(cascade_enable_out_o, 1'b0);
    chk_bit(config_clock_out_oe_n_o, 1'b0);
    c0 = config_clock_out_o;
    repeat (4) @(posedge clk_i);
    #1;
    chk_bit(config_clock_out_o, ~c0);
    $display("test osc done");
    stop_test();
  end
endmodule
